// ===== logic/cap_sense_pkg.sv
// Package with register layout, field positions and shared types of the cap-sense control block
package cap_sense_pkg;

	localparam logic [7:0] CTRL_ADDR = 8'h9a;
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam int ENABLE_BIT = 7;
	localparam int PME_BIT = 6;
	localparam int DONE_BIT = 5;
	localparam int BUSY_BIT = 4;
	localparam int CMPEN_BIT = 3;
	localparam int CMPF_BIT = 0;
	localparam logic [7:0] WRITABLE_MASK = 8'hf8;
	localparam logic [2:0] MODE_SW_A = 3'h0;
	localparam logic [2:0] MODE_SW_B = 3'h6;
	localparam logic [2:0] MODE_SW_C = 3'h7;
	localparam int RESULT_W = 16;
	localparam logic [15:0] CONV_CYCLES_DEF = 16'h0010;

	// Register access strobe group
	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} sfr_req_t;

	// Conversion engine status towards the control register
	typedef struct packed {
		logic done;
		logic [15:0] result;
	} conv_out_t;

endpackage

// ===== logic/cap_sense_engine.sv
// Conversion sequencer: counts a fixed conversion time and emits a result with a done pulse
module cap_sense_engine #(
	parameter logic [15:0] CONV_CYCLES = cap_sense_pkg::CONV_CYCLES_DEF
) (
	input wire logic clk_in, // System clock
	input wire logic arst_n_in, // Async reset, active low
	input wire logic ce_in, // Clock enable
	input wire logic enable_in, // Converter powered
	input wire logic start_in, // Start pulse
	input wire logic [15:0] sample_in, // Accumulated measurement
	output cap_sense_pkg::conv_out_t conv_out, // Done pulse and result
	output logic busy_out // Conversion running
);

	// A zero conversion time would wrap the count to 16'hffff and stay in the running state for 65536 cycles
	if (CONV_CYCLES == 16'h0000) begin : g_bad_cycles
		$error("CONV_CYCLES must be nonzero");
	end

	typedef enum logic [0:0] {IDLE, CONVERT} eng_state_t;
	eng_state_t state_ff;
	logic [15:0] count_ff;
	cap_sense_pkg::conv_out_t out_ff;

	////////////////////////////////////////////////////////////////
	// Sequencer; disable aborts a running conversion
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			state_ff <= IDLE;
			count_ff <= 16'h0000;
		end else if (ce_in) begin
			case (state_ff)
				IDLE: begin
					if (start_in && enable_in) begin
						state_ff <= CONVERT;
						count_ff <= CONV_CYCLES - 16'h0001;
					end
				end
				CONVERT: begin
					if (!enable_in) state_ff <= IDLE;
					else if (count_ff == 16'h0000) state_ff <= IDLE;
					else count_ff <= count_ff - 16'h0001;
				end
				default: state_ff <= IDLE;
			endcase
		end
	end

	// Result register with one-cycle done pulse
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			out_ff <= '0;
		end else if (ce_in) begin
			out_ff.done <= (state_ff == CONVERT) && enable_in && (count_ff == 16'h0000);
			if ((state_ff == CONVERT) && (count_ff == 16'h0000)) out_ff.result <= sample_in;
		end
	end

	assign conv_out = out_ff;
	assign busy_out = (state_ff == CONVERT);

endmodule

// ===== logic/cap_sense_control_reg.sv
// Control and status register of the capacitive-sense converter
module cap_sense_control_reg #(
	parameter logic [15:0] CONV_CYCLES = cap_sense_pkg::CONV_CYCLES_DEF
) (
	input wire logic clk_in, // System clock
	input wire logic arst_n_in, // Async reset, active low
	input wire logic ce_in, // Clock enable, freezes state when low
	input cap_sense_pkg::sfr_req_t sfr_in, // Register access strobes
	input wire logic [2:0] conversion_mode_field_in, // Start source select
	input wire logic [7:0] threshold_high_byte_in, // Threshold upper byte
	input wire logic [7:0] threshold_low_byte_in, // Threshold lower byte
	input wire logic [15:0] sample_in, // Accumulated measurement
	input wire logic retry_pin_event_in, // Retry pulse from pin monitor
	output logic [7:0] rdata_out, // Read data
	output logic converter_power_out, // Converter analog enable
	output logic [15:0] result_out // Last conversion result
);

	logic converter_enable_ff;
	logic pin_monitor_event_flag_ff;
	logic conversion_done_flag_ff;
	logic comparator_enable_ff;
	logic comparator_flag_ff;
	logic [7:0] rdata_ff;
	logic [15:0] result_ff;
	logic busy;
	logic busy_status;
	logic start;
	logic ctrl_wr;
	cap_sense_pkg::conv_out_t conv;

	// Software start source decode
	function automatic logic sw_mode(input logic [2:0] m);
		sw_mode = (m == cap_sense_pkg::MODE_SW_A) || (m == cap_sense_pkg::MODE_SW_B)
			|| (m == cap_sense_pkg::MODE_SW_C);
	endfunction

	////////////////////////////////////////////////////////////////
	// Access decode and start strobe
	always_comb begin
		if (sfr_in.addr == cap_sense_pkg::CTRL_ADDR) ctrl_wr = sfr_in.wr;
		else ctrl_wr = 1'b0;
	end
	assign start = ctrl_wr && sfr_in.wdata[cap_sense_pkg::BUSY_BIT]
		&& sw_mode(conversion_mode_field_in) && !busy_status;

	cap_sense_engine #(
		.CONV_CYCLES(CONV_CYCLES)
	) u_engine (
		.clk_in(clk_in),
		.arst_n_in(arst_n_in),
		.ce_in(ce_in),
		.enable_in(converter_enable_ff),
		.start_in(start),
		.sample_in(sample_in),
		.conv_out(conv),
		.busy_out(busy)
	);

	// Busy spans the done pulse so it falls on the edge that raises the flags
	assign busy_status = (busy || conv.done) && converter_enable_ff;

	////////////////////////////////////////////////////////////////
	// Control bits written by software
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			converter_enable_ff <= cap_sense_pkg::CTRL_RESET[cap_sense_pkg::ENABLE_BIT];
			comparator_enable_ff <= cap_sense_pkg::CTRL_RESET[cap_sense_pkg::CMPEN_BIT];
		end else if (ce_in && ctrl_wr) begin
			converter_enable_ff <= sfr_in.wdata[cap_sense_pkg::ENABLE_BIT];
			comparator_enable_ff <= sfr_in.wdata[cap_sense_pkg::CMPEN_BIT];
		end
	end

	// Pin-monitor flag, set wins over clear
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			pin_monitor_event_flag_ff <= 1'b0;
		end else if (ce_in) begin
			if (retry_pin_event_in) pin_monitor_event_flag_ff <= 1'b1;
			else if (ctrl_wr) pin_monitor_event_flag_ff <= sfr_in.wdata[cap_sense_pkg::PME_BIT];
		end
	end

	// Completion flag and result, set wins over clear
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			conversion_done_flag_ff <= 1'b0;
			result_ff <= 16'h0000;
		end else if (ce_in) begin
			if (conv.done) begin
				conversion_done_flag_ff <= 1'b1;
				result_ff <= conv.result;
			end else if (ctrl_wr) begin
				conversion_done_flag_ff <= sfr_in.wdata[cap_sense_pkg::DONE_BIT];
			end
		end
	end

	// Digital comparator flag, evaluated with the done pulse
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			comparator_flag_ff <= 1'b0;
		end else if (ce_in) begin
			if (conv.done && comparator_enable_ff
				&& (conv.result > {threshold_high_byte_in, threshold_low_byte_in})) begin
				comparator_flag_ff <= 1'b1;
			end else if (ctrl_wr && !sfr_in.wdata[cap_sense_pkg::CMPF_BIT]) begin
				comparator_flag_ff <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// Registered read data
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			rdata_ff <= 8'h00;
		end else if (ce_in) begin
			if (sfr_in.rd && (sfr_in.addr == cap_sense_pkg::CTRL_ADDR)) begin
				rdata_ff <= {converter_enable_ff, pin_monitor_event_flag_ff,
					conversion_done_flag_ff, busy_status, comparator_enable_ff,
					2'b00, comparator_flag_ff};
			end else begin
				rdata_ff <= 8'h00;
			end
		end
	end

	assign rdata_out = rdata_ff;
	assign converter_power_out = converter_enable_ff;
	assign result_out = result_ff;

endmodule

// ===== bench/cap_sense_asserts.sv
// Port checker for the cap-sense control register
module cap_sense_asserts #(
	parameter logic [15:0] CONV_CYCLES = 16'h0010
) (
	input wire logic clk_in, // Clock
	input wire logic arst_n_in, // Reset
	input wire logic ce_in, // Enable
	input cap_sense_pkg::sfr_req_t sfr_in, // Access
	input wire logic retry_pin_event_in, // Retry
	input wire logic [7:0] rdata_out, // Data
	input wire logic converter_power_out // Power
);
	default clocking @(posedge clk_in); endclocking
	default disable iff (!arst_n_in);
	logic hit;
	logic rd_q;
	logic [7:0] seen_ff;
	// Access to the control register
	assign hit = ce_in && sfr_in.addr == 8'h9a;
	// Flags seen set since the last write
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			rd_q <= 1'b0;
			seen_ff <= 8'h00;
		end else if (ce_in) begin
			rd_q <= hit && sfr_in.rd;
			seen_ff <= (hit && sfr_in.wr) ? 8'h00 : seen_ff | (rd_q ? rdata_out & 8'h61 : 8'h00);
		end
	end
	chk_power_on_write: assert property (hit && sfr_in.wr |=> converter_power_out == $past(sfr_in.wdata[7]))
		else $error("power bit wrong");
	chk_power_steady: assert property (!(hit && sfr_in.wr) |=> $stable(converter_power_out))
		else $error("power moved");
	chk_read_enable: assert property (hit && sfr_in.rd |=> rdata_out[7] == $past(converter_power_out))
		else $error("enable read wrong");
	chk_unused_low: assert property (rdata_out[2:1] == 2'h0)
		else $error("unused bits set");
	chk_other_zero: assert property (ce_in && sfr_in.rd && sfr_in.addr != 8'h9a |=> rdata_out == 8'h00)
		else $error("other address read");
	chk_pme_sets: assert property (ce_in && retry_pin_event_in ##1 hit && sfr_in.rd |=> rdata_out[6])
		else $error("retry flag missing");
	chk_busy_off_idle: assert property (hit && sfr_in.rd && !converter_power_out |=> !rdata_out[4])
		else $error("busy while off");
	chk_flags_sticky: assert property (rd_q |-> (rdata_out & seen_ff) == seen_ff)
		else $error("flag dropped");
endmodule
bind cap_sense_control_reg cap_sense_asserts #(.CONV_CYCLES(CONV_CYCLES)) i_chk (.clk_in(clk_in),
	.arst_n_in(arst_n_in), .ce_in(ce_in), .sfr_in(sfr_in), .retry_pin_event_in(retry_pin_event_in),
	.rdata_out(rdata_out), .converter_power_out(converter_power_out));

// ===== bench/tb.sv
// Self-checking bench for the cap-sense control register
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk_in = 1'b0;
	logic arst_n_in = 1'b0;
	cap_sense_pkg::sfr_req_t sfr_in = '0;
	logic [2:0] mode = 3'h1;
	logic [15:0] thr = 16'h0000;
	logic [15:0] sample = 16'h0000;
	logic retry = 1'b0;
	logic [7:0] rdata_out;
	logic pwr;
	logic [15:0] res;
	logic pend = 1'b0;
	logic ce = 1'b1;
	logic exp_pwr = 1'b0;
	logic [15:0] exp_res = 16'h0000;
	logic [24:0] note;
	logic [24:0] exp_q[$];
	int num_errors = 0;
	int cmp_count = 0;
	always #50 clk_in = ~clk_in;
	cap_sense_control_reg #(.CONV_CYCLES(16'h0002)) i_dut (.clk_in(clk_in), .arst_n_in(arst_n_in),
		.ce_in(ce), .sfr_in(sfr_in), .conversion_mode_field_in(mode),
		.threshold_high_byte_in(thr[15:8]), .threshold_low_byte_in(thr[7:0]), .sample_in(sample),
		.retry_pin_event_in(retry), .rdata_out(rdata_out), .converter_power_out(pwr), .result_out(res));
	task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			num_errors++;
			$display("wrong value %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic test_done();
		// Notes never answered count as mismatches
		num_errors += exp_q.size();
		$display("errors %0d compares %0d", num_errors, cmp_count);
		if (num_errors == 0 && cmp_count > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	// One access; a read notes its expected answer
	task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
		@(negedge clk_in);
		sfr_in = '{w, !w, a, d};
		if (w && a == cap_sense_pkg::CTRL_ADDR && ce) begin
			exp_pwr = d[7];
		end
		if (!w) begin
			exp_q.push_back({exp_pwr, exp_res, d});
		end
		@(negedge clk_in);
		sfr_in = '0;
	endtask
	// Watcher: read answers against the oldest note
	always @(posedge clk_in) begin
		pend <= sfr_in.rd;
	end
	always @(negedge clk_in) begin
		if (pend) begin
			note = exp_q.pop_front();
			check("rdata_out", {8'h00, rdata_out}, {8'h00, note[7:0]});
			check("result_out", res, note[23:8]);
			check("converter_power_out", {15'h0000, pwr}, {15'h0000, note[24]});
		end
	end
	// Main sequence
	initial begin
		void'($urandom(7));
		repeat (10) @(negedge clk_in);
		arst_n_in = 1'b1;
		acc(0, 8'h9a, 8'h00);
		acc(1, 8'h9a, 8'hff);
		acc(0, 8'h9a, 8'he8);
		acc(1, 8'h00, 8'h00);
		acc(0, 8'h00, 8'h00);
		acc(0, 8'h9a, 8'he8);
		acc(1, 8'h9a, 8'h88);
		for (int i = 0; i < 3; i++) begin
			mode = (i == 0) ? 3'h0 : 3'h5 + 3'(i);
			thr = 16'($urandom) & 16'h7fff;
			sample = thr + ((i == 0) ? 16'h0001 : 16'h0000);
			acc(1, 8'h9a, 8'h98);
			acc(0, 8'h9a, 8'h98);
			exp_res = sample;
			repeat (3) @(negedge clk_in);
			acc(0, 8'h9a, (i == 0) ? 8'ha9 : 8'ha8);
			acc(1, 8'h9a, 8'h88);
		end
		sample = thr + 16'h0001;
		acc(1, 8'h9a, 8'h90);
		repeat (4) @(negedge clk_in);
		exp_res = sample;
		acc(0, 8'h9a, 8'ha0);
		@(negedge clk_in);
		retry = 1'b1;
		acc(0, 8'h9a, 8'he0);
		retry = 1'b0;
		acc(1, 8'h9a, 8'h80);
		acc(0, 8'h9a, 8'h80);
		// A write while the clock enable is low must leave everything frozen
		ce = 1'b0;
		acc(1, 8'h9a, 8'h20);
		ce = 1'b1;
		acc(0, 8'h9a, 8'h80);
		repeat (2) @(negedge clk_in);
		test_done();
	end
	// Watchdog against a hang
	initial begin
		#1000000;
		num_errors++;
		test_done();
	end
endmodule
